/* File: design/measurement_averaging_filter.sv */
// two-channel measurement averaging filter with its settings and command port
// Summary of operation
// R01: manual length write turns automatic off
// R02: manual length write turns averaging on
// R03: length 1..1024; default 4, min 1, max 1024
// R04: reset: length 4, auto, step, averaging on, video 4
// R05: length query returns length or min/max
// R06: write at rate 200: conflict, keep averaging enable
// R07: auto on at rate 200: conflict, averaging untouched
// R08: single-shot value changes nothing
// R09: auto length from resolution and power range
// R10: auto on turns averaging on
// R11: manual mode averages exactly the written length
// R12: measure/configure average power enables auto
// R13: auto step: newest four vs all, 12.5% clears
// R14: auto delay plus free run suppresses step detect
// R15: host disables step detect for pulsed signals
// R16: enable queries answer 1 or 0
// R17: averaging on at rate 200 is a conflict
// R18: averaging on while peak sensor awaits trigger: conflict (flagged only with the sensor in average mode)
// R19: video command without peak sensor: -241
// R20: video command, sensor in average mode: -221
// R21: video length 1..256, powers of two only
// R22: video filter combines successive traces
// R23: video length query returns the length
// R24: channel select; independent settings per channel
// R25: output mean of stored readings, else latest
module measurement_averaging_filter
    import avg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic cmd_valid_i,
    input wire cmd_t cmd_code_i,
    input wire arg_t cmd_arg_i,
    input wire logic cmd_chan_i,
    input wire logic [LEN_W-1:0] cmd_val_i,
    input wire logic [1:0] rate200_i,
    input wire logic [1:0][1:0] resolution_i,
    input wire logic [1:0][1:0] power_range_i,
    input wire logic [1:0] peak_sensor_i,
    input wire logic [1:0] sensor_avg_mode_i,
    input wire logic [1:0] ext_trig_wait_i,
    input wire logic [1:0] auto_trigger_delay_i,
    input wire logic [1:0] free_run_i,
    input wire logic rd_valid_i,
    input wire logic rd_chan_i,
    input wire logic [RD_W-1:0] rd_data_i,
    output logic rd_ready_o,
    output logic avg_valid_o,
    output logic avg_chan_o,
    output logic [RD_W-1:0] avg_data_o,
    input wire logic tr_valid_i,
    input wire logic tr_chan_i,
    input wire logic [TR_AW-1:0] tr_idx_i,
    input wire logic [RD_W-1:0] tr_data_i,
    output logic tr_out_valid_o,
    output logic [RD_W-1:0] tr_out_o,
    output logic resp_valid_o,
    output logic [LEN_W-1:0] resp_data_o,
    output logic err_valid_o,
    output logic [15:0] err_code_o
);
    typedef enum logic [1:0] {F_IDLE, F_ACC, F_STEP, F_DIV} fst_t;

    typedef struct packed {
        logic [1:0][LEN_W-1:0] flen;
        logic [1:0] auto_en;
        logic [1:0] step_detect_enable;
        logic [1:0] avg_en;
        logic [1:0] ven;
        logic [1:0][3:0] vlog;
        logic resp_v;
        logic [LEN_W-1:0] resp_d;
        logic err_v;
        logic [15:0] err_c;
        fst_t fst;
        logic ch;
        logic [RD_W-1:0] x;
        logic [1:0][PTR_W-1:0] ptr;
        logic [1:0][LEN_W-1:0] cnt;
        logic [1:0][LEN_W-1:0] lseen;
        logic [1:0][SUM_W-1:0] sum;
        logic [1:0][S4_W-1:0] sum4;
        logic [1:0][2:0] n4;
        logic [SUM_W-1:0] num;
        logic [SUM_W-1:0] q;
        logic [LEN_W-1:0] den;
        logic [LEN_W-1:0] rem;
        logic [4:0] dcnt;
        logic ov;
        logic och;
        logic [RD_W-1:0] oval;
    } ctl_t;

    ctl_t st_r, st_nxt;
    logic [RD_W-1:0] fmem [0:2**(PTR_W+1)-1];
    logic [1:0][LEN_W-1:0] elen;
    logic [1:0] sdet;
    logic f_valid, pop, wr, c, h, fc, vid, vbad, full, big, ge;
    logic [RD_W:0] f_data;
    logic [RD_W-1:0] old, old4;
    logic [31:0] a, b, d;
    logic [LEN_W:0] r;

    trace_cfg_if tcfg ();

    function automatic logic [LEN_W-1:0] pick_len(input arg_t k, input logic [LEN_W-1:0] v);
        if (k == A_DEF) pick_len = LEN_DEF;
        else if (k == A_MIN) pick_len = LEN_MIN;
        else if (k == A_MAX || v > LEN_MAX) pick_len = LEN_MAX;
        else if (v < LEN_MIN) pick_len = LEN_MIN;
        else pick_len = v;
    endfunction

    // values between powers of two round down to the power below
    function automatic logic [3:0] vid_log(input arg_t k, input logic [LEN_W-1:0] v);
        logic [3:0] l;
        l = 4'h0;
        for (int i = 0; i <= int'(VLOG_MAX); i++) begin
            if (v[i]) l = 4'(i);
        end
        if (k == A_DEF) l = VLOG_DEF;
        else if (k == A_MAX || v >= VLEN_MAX) l = VLOG_MAX;
        else if (k == A_MIN) l = 4'h0;
        vid_log = l;
    endfunction

    genvar g;
    for (g = 0; g < 2; g++) begin : g_chan
        assign elen[g] = st_r.auto_en[g] ?
            auto_len(resolution_i[g], power_range_i[g]) : st_r.flen[g]; // [R09] [R11] [R24]
        assign sdet[g] = st_r.step_detect_enable[g] &
            ~(auto_trigger_delay_i[g] & free_run_i[g]); // [R14]
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.resp_v = 1'b0;
        st_nxt.err_v = 1'b0;
        st_nxt.ov = 1'b0;
        pop = 1'b0;
        wr = 1'b0;
        c = cmd_chan_i;
        h = st_r.ch;
        fc = f_data[RD_W];
        full = st_r.cnt[h] == st_r.lseen[h];
        old = fmem[{h, st_r.ptr[h] - st_r.lseen[h][PTR_W-1:0]}];
        old4 = fmem[{h, st_r.ptr[h] - PTR_W'(STEP_N)}];
        a = 32'(st_r.sum4[h]) * 32'(st_r.cnt[h]);
        b = 32'({st_r.sum[h], 2'b00});
        d = (a > b) ? a - b : b - a;
        // |4*sum4*cnt/4 - 4*sum| scaled: mean gap above one eighth of the mean
        big = {d[30:0], 1'b0} > 32'(st_r.sum[h]);
        r = {st_r.rem, st_r.num[SUM_W-1]};
        ge = r >= {1'b0, st_r.den};
        vid = cmd_code_i inside {C_VLEN, C_VLEN_Q, C_VAVG, C_VAVG_Q};
        vbad = vid && (!peak_sensor_i[c] || sensor_avg_mode_i[c]);

        if (cmd_valid_i && vbad) begin
            st_nxt.err_v = 1'b1;
            st_nxt.err_c = peak_sensor_i[c] ? ERR_CONFLICT : ERR_MISSING; // [R19] [R20]
        end else if (cmd_valid_i) begin
            case (cmd_code_i)
                C_LEN: begin
                    st_nxt.flen[c] = pick_len(cmd_arg_i, cmd_val_i); // [R03]
                    st_nxt.auto_en[c] = 1'b0; // [R01]
                    if (rate200_i[c]) begin
                        st_nxt.err_v = 1'b1; // [R06]
                        st_nxt.err_c = ERR_CONFLICT;
                    end else begin
                        st_nxt.avg_en[c] = 1'b1; // [R02]
                    end
                end
                C_LEN_Q: begin
                    st_nxt.resp_v = 1'b1;
                    if (cmd_arg_i == A_MIN) st_nxt.resp_d = LEN_MIN; // [R05]
                    else if (cmd_arg_i == A_MAX) st_nxt.resp_d = LEN_MAX;
                    else st_nxt.resp_d = elen[c];
                end
                C_AUTO, C_MEAS: begin
                    // single-shot is accepted silently and alters nothing
                    if (cmd_arg_i != A_SINGLE_SHOT_VALUE) begin // [R08]
                        st_nxt.auto_en[c] = (cmd_code_i == C_MEAS) || cmd_val_i[0]; // [R12]
                        if (st_nxt.auto_en[c] && rate200_i[c]) begin
                            st_nxt.err_v = 1'b1; // [R07]
                            st_nxt.err_c = ERR_CONFLICT;
                        end else if (st_nxt.auto_en[c]) begin
                            st_nxt.avg_en[c] = 1'b1; // [R10]
                        end
                    end
                end
                C_AUTO_Q: begin
                    st_nxt.resp_v = 1'b1;
                    st_nxt.resp_d = LEN_W'(st_r.auto_en[c]); // [R16]
                end
                C_STEP: st_nxt.step_detect_enable[c] = cmd_val_i[0];
                C_STEP_Q: begin
                    st_nxt.resp_v = 1'b1;
                    st_nxt.resp_d = LEN_W'(st_r.step_detect_enable[c]); // [R16]
                end
                C_AVG: begin
                    // the setting is taken even when a conflict is reported
                    st_nxt.avg_en[c] = cmd_val_i[0];
                    if (cmd_val_i[0] && (rate200_i[c] ||
                        (peak_sensor_i[c] && sensor_avg_mode_i[c] && ext_trig_wait_i[c]))) begin
                        st_nxt.err_v = 1'b1; // [R17] [R18]
                        st_nxt.err_c = ERR_CONFLICT;
                    end
                end
                C_AVG_Q: begin
                    st_nxt.resp_v = 1'b1;
                    st_nxt.resp_d = LEN_W'(st_r.avg_en[c]); // [R16]
                end
                C_VLEN: st_nxt.vlog[c] = vid_log(cmd_arg_i, cmd_val_i); // [R21]
                C_VLEN_Q: begin
                    st_nxt.resp_v = 1'b1;
                    st_nxt.resp_d = LEN_W'(1) << st_r.vlog[c]; // [R23]
                end
                C_VAVG: st_nxt.ven[c] = cmd_val_i[0];
                C_VAVG_Q: begin
                    st_nxt.resp_v = 1'b1;
                    st_nxt.resp_d = LEN_W'(st_r.ven[c]); // [R16]
                end
                default: st_nxt.resp_v = 1'b0;
            endcase
        end

        case (st_r.fst)
            F_IDLE: begin
                if (f_valid) begin
                    pop = 1'b1;
                    st_nxt.ch = fc;
                    st_nxt.x = f_data[RD_W-1:0];
                    // a new length restarts the filter: old entries may exceed it
                    if (st_r.lseen[fc] != elen[fc]) begin
                        st_nxt.lseen[fc] = elen[fc];
                        st_nxt.cnt[fc] = '0;
                        st_nxt.sum[fc] = '0;
                        st_nxt.sum4[fc] = '0;
                        st_nxt.n4[fc] = '0;
                    end
                    st_nxt.fst = F_ACC;
                end
            end
            F_ACC: begin
                wr = 1'b1;
                st_nxt.sum[h] = st_r.sum[h] + SUM_W'(st_r.x) - (full ? SUM_W'(old) : '0); // [R25]
                st_nxt.sum4[h] = st_r.sum4[h] + S4_W'(st_r.x) -
                    ((st_r.n4[h] == STEP_N) ? S4_W'(old4) : '0);
                if (st_r.n4[h] != STEP_N) st_nxt.n4[h] = st_r.n4[h] + 3'h1;
                if (!full) st_nxt.cnt[h] = st_r.cnt[h] + 11'h001;
                st_nxt.ptr[h] = st_r.ptr[h] + 10'h001;
                st_nxt.fst = F_STEP;
            end
            F_STEP: begin
                if (st_r.auto_en[h] && sdet[h] && st_r.cnt[h] >= LEN_W'(STEP_N) && big) begin
                    st_nxt.cnt[h] = 11'h001; // [R13]
                    st_nxt.sum[h] = SUM_W'(st_r.x);
                    st_nxt.sum4[h] = S4_W'(st_r.x);
                    st_nxt.n4[h] = 3'h1;
                end
                if (!st_r.avg_en[h]) begin
                    st_nxt.ov = 1'b1; // [R25]
                    st_nxt.oval = st_r.x;
                    st_nxt.och = h;
                    st_nxt.fst = F_IDLE;
                end else begin
                    st_nxt.num = st_nxt.sum[h];
                    st_nxt.den = st_nxt.cnt[h];
                    st_nxt.rem = '0;
                    st_nxt.dcnt = '0;
                    st_nxt.fst = F_DIV;
                end
            end
            F_DIV: begin
                // one quotient bit a cycle keeps the divider small
                st_nxt.rem = ge ? LEN_W'(r - {1'b0, st_r.den}) : LEN_W'(r);
                st_nxt.q = {st_r.q[SUM_W-2:0], ge};
                st_nxt.num = {st_r.num[SUM_W-2:0], 1'b0};
                st_nxt.dcnt = st_r.dcnt + 5'h01;
                if (st_r.dcnt == 5'(DIV_STEPS - 1)) begin
                    st_nxt.ov = 1'b1; // [R25]
                    st_nxt.oval = st_nxt.q[RD_W-1:0];
                    st_nxt.och = h;
                    st_nxt.fst = F_IDLE;
                end
            end
            default: st_nxt.fst = F_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
            st_r.flen <= {LEN_DEF, LEN_DEF}; // [R04]
            st_r.auto_en <= {RST_AUTO, RST_AUTO};
            st_r.step_detect_enable <= {RST_STEP, RST_STEP};
            st_r.avg_en <= {RST_AVG, RST_AVG};
            st_r.ven <= {RST_VAVG, RST_VAVG};
            st_r.vlog <= {VLOG_DEF, VLOG_DEF};
            st_r.fst <= F_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (wr) fmem[{st_r.ch, st_r.ptr[st_r.ch]}] <= st_r.x;
    end

    assign tcfg.vlog = st_r.vlog;
    assign tcfg.ven = st_r.ven;

    reading_fifo #(.W(RD_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .in_valid_i(rd_valid_i),
        .in_ready_o(rd_ready_o),
        .in_data_i({rd_chan_i, rd_data_i}),
        .out_valid_o(f_valid),
        .out_ready_i(pop),
        .out_data_o(f_data)
    );

    trace_averager u_trace (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .cfg(tcfg.avg),
        .tr_valid_i(tr_valid_i),
        .tr_chan_i(tr_chan_i),
        .tr_idx_i(tr_idx_i),
        .tr_data_i(tr_data_i),
        .out_valid_o(tr_out_valid_o),
        .out_o(tr_out_o)
    );

    assign avg_valid_o = st_r.ov;
    assign avg_chan_o = st_r.och;
    assign avg_data_o = st_r.oval;
    assign resp_valid_o = st_r.resp_v;
    assign resp_data_o = st_r.resp_d;
    assign err_valid_o = st_r.err_v;
    assign err_code_o = st_r.err_c;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    a_len_clears_auto: assert property ( // [R01]
        cmd_valid_i && !cmd_chan_i && cmd_code_i == C_LEN |=> !st_r.auto_en[0])
        else $error("length write left automatic mode on");
    a_len_sets_avg: assert property ( // [R02]
        cmd_valid_i && !cmd_chan_i && cmd_code_i == C_LEN && !rate200_i[0]
        |=> st_r.avg_en[0] && !err_valid_o)
        else $error("length write did not enable averaging");
    a_len_in_range: assert property ( // [R03]
        st_r.flen[0] >= LEN_MIN && st_r.flen[0] <= LEN_MAX)
        else $error("filter length out of range");
    a_rate_conflict: assert property ( // [R06]
        cmd_valid_i && !cmd_chan_i && cmd_code_i == C_LEN && rate200_i[0]
        |=> err_valid_o && err_code_o == ERR_CONFLICT && $stable(st_r.avg_en))
        else $error("rate conflict not flagged or averaging changed");
    a_single_shot_value_no_effect: assert property ( // [R08]
        cmd_valid_i && cmd_code_i == C_AUTO && cmd_arg_i == A_SINGLE_SHOT_VALUE
        |=> $stable(st_r.auto_en) && $stable(st_r.avg_en) && !err_valid_o)
        else $error("single-shot value changed state");
    a_auto_sets_avg: assert property ( // [R10]
        cmd_valid_i && !cmd_chan_i && cmd_code_i == C_AUTO && cmd_arg_i != A_SINGLE_SHOT_VALUE &&
        cmd_val_i[0] && !rate200_i[0] |=> st_r.avg_en[0] && st_r.auto_en[0])
        else $error("auto on did not enable averaging");
    a_meas_sets_auto: assert property ( // [R12]
        cmd_valid_i && !cmd_chan_i && cmd_code_i == C_MEAS |=> st_r.auto_en[0])
        else $error("measure command did not enable auto");
    a_bool_query: assert property ( // [R16]
        cmd_valid_i && !cmd_chan_i && cmd_code_i == C_STEP_Q
        |=> resp_valid_o && resp_data_o == LEN_W'($past(st_r.step_detect_enable[0])))
        else $error("step detect query answer wrong");
    a_video_missing: assert property ( // [R19]
        cmd_valid_i && vid && !peak_sensor_i[cmd_chan_i]
        |=> err_valid_o && err_code_o == ERR_MISSING && !resp_valid_o)
        else $error("missing sensor not reported");
    a_video_pow2: assert property ( // [R21]
        st_r.vlog[0] <= VLOG_MAX && st_r.vlog[1] <= VLOG_MAX)
        else $error("video length beyond 256");
    a_mean_ready: assert property ( // [R25]
        st_r.fst == F_STEP |-> ##[1:27] avg_valid_o)
        else $error("filter output late");
endmodule

/* File: shared/avg_pkg.sv */
// constants and types shared by the averaging filter files
package avg_pkg;
    localparam int RD_W = 16;
    localparam int LEN_W = 11;
    localparam int SUM_W = 26;
    localparam int S4_W = 18;
    localparam int PTR_W = 10;
    localparam int FIFO_DEPTH = 16;
    localparam int TR_AW = 6;
    localparam int DIV_STEPS = 26;
    localparam logic [10:0] LEN_MIN = 11'h001;
    localparam logic [10:0] LEN_MAX = 11'h400;
    localparam logic [10:0] LEN_DEF = 11'h004;
    localparam logic [3:0] VLOG_DEF = 4'h2;
    localparam logic [3:0] VLOG_MAX = 4'h8;
    localparam logic [10:0] VLEN_MAX = 11'h100;
    localparam logic [2:0] STEP_N = 3'h4;
    localparam logic [15:0] ERR_CONFLICT = 16'hff23;
    localparam logic [15:0] ERR_MISSING = 16'hff0f;
    localparam logic RST_AUTO = 1'b1;
    localparam logic RST_STEP = 1'b1;
    localparam logic RST_AVG = 1'b1;
    localparam logic RST_VAVG = 1'b1;
    // automatic length by {resolution, power range}
    localparam logic [0:15][10:0] AUTO_TBL = {
        11'h001, 11'h001, 11'h001, 11'h008,
        11'h001, 11'h001, 11'h004, 11'h010,
        11'h008, 11'h010, 11'h020, 11'h080,
        11'h020, 11'h040, 11'h100, 11'h400};
    typedef enum logic [3:0] {
        C_LEN, C_LEN_Q, C_AUTO, C_AUTO_Q, C_STEP, C_STEP_Q, C_AVG, C_AVG_Q,
        C_MEAS, C_VLEN, C_VLEN_Q, C_VAVG, C_VAVG_Q
    } cmd_t;
    typedef enum logic [2:0] {A_NUM, A_DEF, A_MIN, A_MAX, A_SINGLE_SHOT_VALUE} arg_t;
    function automatic logic [10:0] auto_len(input logic [1:0] res, input logic [1:0] rng);
        auto_len = AUTO_TBL[{res, rng}];
    endfunction
endpackage

/* File: shared/trace_cfg_if.sv */
// video averaging settings passed to the trace averager
interface trace_cfg_if;
    logic [1:0][3:0] vlog;
    logic [1:0] ven;
    modport ctrl (output vlog, output ven);
    modport avg (input vlog, input ven);
endinterface

/* File: design/reading_fifo.sv */
// reading fifo with registered input ready
module reading_fifo #(
    parameter int W = 17,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } fifo_t;
    fifo_t st_r, st_nxt;
    logic [W-1:0] mem [0:DEPTH-1];
    logic push, pop;
    always_comb begin
        st_nxt = st_r;
        push = in_valid_i && st_r.rdy;
        pop = out_ready_i && (st_r.cnt != '0);
        if (push) st_nxt.wp = st_r.wp + 1'b1;
        if (pop) st_nxt.rp = st_r.rp + 1'b1;
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // ready is registered from the next count, so it drops exactly when the fifo fills
        st_nxt.rdy = st_nxt.cnt < (AW+1)'(DEPTH);
    end
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (push) mem[st_r.wp] <= in_data_i;
    end
    assign in_ready_o = st_r.rdy;
    assign out_valid_o = st_r.cnt != '0;
    assign out_data_o = mem[st_r.rp];
endmodule

/* File: design/trace_averager.sv */
// video averaging of captured traces, one stored point per channel and index
module trace_averager
    import avg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    trace_cfg_if.avg cfg,
    input wire logic tr_valid_i,
    input wire logic tr_chan_i,
    input wire logic [TR_AW-1:0] tr_idx_i,
    input wire logic [RD_W-1:0] tr_data_i,
    output logic out_valid_o,
    output logic [RD_W-1:0] out_o
);
    typedef struct packed {
        logic [2**(TR_AW+1)-1:0] seen;
        logic ov;
        logic [RD_W-1:0] o;
    } tr_t;
    tr_t st_r, st_nxt;
    logic [RD_W-1:0] ymem [0:2**(TR_AW+1)-1];
    logic [TR_AW:0] a;
    logic [RD_W-1:0] y, nv;
    logic signed [RD_W:0] dif, sh;
    always_comb begin
        st_nxt = st_r;
        a = {tr_chan_i, tr_idx_i};
        y = ymem[a];
        dif = $signed({1'b0, tr_data_i}) - $signed({1'b0, y});
        // weight 1/2^n: a recursive mean over 2^n traces, shape kept per point
        sh = dif >>> cfg.vlog[tr_chan_i];
        nv = (cfg.ven[tr_chan_i] && st_r.seen[a]) ? y + sh[RD_W-1:0] : tr_data_i; // [R22]
        st_nxt.ov = tr_valid_i;
        if (tr_valid_i) begin
            st_nxt.o = nv;
            st_nxt.seen[a] = 1'b1;
        end
    end
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (tr_valid_i) ymem[a] <= nv;
    end
    assign out_valid_o = st_r.ov;
    assign out_o = st_r.o;
endmodule

/* File: sim/sensor_model.sv */
// power sensor model that offers readings to the filter one at a time
module sensor_model
    import avg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rd_ready_i,
    output logic rd_valid_o,
    output logic rd_chan_o,
    output logic [RD_W-1:0] rd_data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [RD_W-1:0] pend_q[$];
    logic [RD_W-1:0] last_r = '0;
    initial begin
        rd_valid_o = 1'b0;
        rd_chan_o = 1'b0;
        rd_data_o = '1;
    end
    task automatic push(input logic [RD_W-1:0] v);
        pend_q.push_back(v);
    endtask
    // held until taken; released data shows the inverse so a stale value cannot pass
    always @(posedge clk_sys_i) begin
        if (rd_valid_o && rd_ready_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= ~last_r;
        end else if (!rd_valid_o && pend_q.size() > 0) begin
            last_r <= pend_q[0];
            rd_data_o <= pend_q.pop_front();
            rd_valid_o <= 1'b1;
        end
    end
endmodule

/* File: sim/measurement_averaging_filter_tb.sv */
// self-checking bench for the averaging filter
module measurement_averaging_filter_tb;
    import avg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic c_vld = 1'b0;
    cmd_t c_code = C_LEN_Q;
    arg_t c_arg = A_NUM;
    logic c_chan = 1'b0;
    logic [LEN_W-1:0] c_val = '0;
    logic [1:0] rate200 = 2'h0, peak = 2'h3, smode = 2'h0, ext = 2'h0, sup = 2'h0;
    logic [1:0][1:0] res = 4'h5, rng = 4'ha;
    logic tr_vld = 1'b0;
    logic [RD_W-1:0] tr_dat = '0;
    logic rd_vld, rd_ch, rd_rdy, av_vld, av_ch, tr_ov, r_vld, e_vld;
    logic [RD_W-1:0] rd_dat, av_dat, tr_o, e_code;
    logic [LEN_W-1:0] r_dat;
    logic [RD_W-1:0] got[$];
    int bad_count = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    measurement_averaging_filter u_measurement_averaging_filter (.clk_sys_i(clk),
        .reset_i(rst), .cmd_valid_i(c_vld), .cmd_code_i(c_code), .cmd_arg_i(c_arg),
        .cmd_chan_i(c_chan), .cmd_val_i(c_val), .rate200_i(rate200), .resolution_i(res),
        .power_range_i(rng), .peak_sensor_i(peak), .sensor_avg_mode_i(smode),
        .ext_trig_wait_i(ext), .auto_trigger_delay_i(sup), .free_run_i(sup),
        .rd_valid_i(rd_vld), .rd_chan_i(rd_ch), .rd_data_i(rd_dat), .rd_ready_o(rd_rdy),
        .avg_valid_o(av_vld), .avg_chan_o(av_ch), .avg_data_o(av_dat), .tr_valid_i(tr_vld),
        .tr_chan_i(1'b0), .tr_idx_i(6'h00), .tr_data_i(tr_dat), .tr_out_valid_o(tr_ov),
        .tr_out_o(tr_o), .resp_valid_o(r_vld), .resp_data_o(r_dat), .err_valid_o(e_vld),
        .err_code_o(e_code));
    sensor_model u_sensor_model (.clk_sys_i(clk), .rd_ready_i(rd_rdy), .rd_valid_o(rd_vld),
        .rd_chan_o(rd_ch), .rd_data_o(rd_dat));
    always @(posedge clk) if (av_vld === 1'b1) got.push_back(av_dat);
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        num_checks++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic cmd(input cmd_t c, input arg_t a, input logic [LEN_W-1:0] v);
        @(posedge clk);
        c_vld <= 1'b1;
        c_code <= c;
        c_arg <= a;
        c_val <= v;
        @(posedge clk);
        c_vld <= 1'b0;
        #1;
    endtask
    task automatic q(input cmd_t c, input arg_t a, input logic [15:0] x);
        cmd(c, a, '0);
        chk(r_vld === 1'b1 ? {5'h00, r_dat} : 16'hdead, x);
    endtask
    task automatic e(input cmd_t c, input logic [LEN_W-1:0] v, input logic [15:0] x);
        cmd(c, A_NUM, v);
        chk(e_vld === 1'b1 ? e_code : 16'h0000, x);
    endtask
    task automatic set_in(input logic [1:0] r, input logic [1:0] s, input logic [1:0] t);
        @(posedge clk);
        rate200 <= r;
        smode <= s;
        ext <= t;
    endtask
    task automatic t_reset();
        q(C_LEN_Q, A_NUM, 16'h0004);
        q(C_AUTO_Q, A_NUM, 16'h0001);
        q(C_STEP_Q, A_NUM, 16'h0001);
        q(C_AVG_Q, A_NUM, 16'h0001);
        q(C_VLEN_Q, A_NUM, 16'h0004);
    endtask
    task automatic t_manual();
        e(C_AVG, 11'h000, 16'h0000);
        e(C_LEN, 11'h190, 16'h0000);
        q(C_AUTO_Q, A_NUM, 16'h0000);
        q(C_AVG_Q, A_NUM, 16'h0001);
        q(C_LEN_Q, A_NUM, 16'h0190);
        q(C_LEN_Q, A_MIN, 16'h0001);
        q(C_LEN_Q, A_MAX, 16'h0400);
        cmd(C_LEN, A_MAX, '0);
        q(C_LEN_Q, A_NUM, 16'h0400);
        cmd(C_LEN, A_DEF, '0);
        q(C_LEN_Q, A_NUM, 16'h0004);
        cmd(C_AUTO, A_SINGLE_SHOT_VALUE, '0);
        q(C_AUTO_Q, A_NUM, 16'h0000);
        @(posedge clk);
        c_chan <= 1'b1;
        q(C_AUTO_Q, A_NUM, 16'h0001);
        @(posedge clk);
        c_chan <= 1'b0;
        e(C_AVG, 11'h000, 16'h0000);
        e(C_MEAS, 11'h000, 16'h0000);
        q(C_AUTO_Q, A_NUM, 16'h0001);
        q(C_AVG_Q, A_NUM, 16'h0001);
    endtask
    task automatic t_rate();
        set_in(2'h1, 2'h0, 2'h0);
        e(C_AVG, 11'h000, 16'h0000);
        e(C_LEN, 11'h010, 16'hff23);
        q(C_LEN_Q, A_NUM, 16'h0010);
        q(C_AVG_Q, A_NUM, 16'h0000);
        e(C_AUTO, 11'h001, 16'hff23);
        q(C_AUTO_Q, A_NUM, 16'h0001);
        q(C_AVG_Q, A_NUM, 16'h0000);
        e(C_AVG, 11'h001, 16'hff23);
        set_in(2'h0, 2'h1, 2'h1);
        e(C_AVG, 11'h001, 16'hff23);
        set_in(2'h0, 2'h0, 2'h0);
    endtask
    task automatic t_video();
        @(posedge clk);
        peak <= 2'h2;
        e(C_VLEN, 11'h010, 16'hff0f);
        set_in(2'h0, 2'h1, 2'h0);
        peak <= 2'h3;
        e(C_VAVG, 11'h001, 16'hff23);
        set_in(2'h0, 2'h0, 2'h0);
        q(C_VAVG_Q, A_NUM, 16'h0001);
        e(C_VLEN, 11'h12c, 16'h0000);
        q(C_VLEN_Q, A_NUM, 16'h0100);
        e(C_VLEN, 11'h004, 16'h0000);
        @(posedge clk);
        tr_vld <= 1'b1;
        tr_dat <= 16'h0100;
        @(posedge clk);
        tr_dat <= 16'h0200;
        #1 chk(tr_o, 16'h0100);
        chk({15'h0000, tr_ov}, 16'h0001);
        @(posedge clk);
        tr_vld <= 1'b0;
        #1 chk(tr_o, 16'h0140);
    endtask
    task automatic wait_got(input int k);
        for (int n = 0; n < 300 && got.size() < k; n++) @(posedge clk);
        if (got.size() < k) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic t_read();
        e(C_LEN, 11'h002, 16'h0000);
        u_sensor_model.push(16'h000a);
        u_sensor_model.push(16'h0014);
        u_sensor_model.push(16'h0028);
        wait_got(3);
        chk(got[0], 16'h000a);
        chk(got[1], 16'h000f);
        chk(got[2], 16'h001e);
    endtask
    task automatic t_step();
        res <= 4'hf;
        sup <= 2'h3;
        cmd(C_AUTO, A_NUM, 11'h001);
        repeat (4) u_sensor_model.push(16'h0010);
        u_sensor_model.push(16'h00a0);
        q(C_STEP_Q, A_NUM, 16'h0001);
        wait_got(8);
        chk(got[7], 16'h002c);
        sup <= 2'h0;
        u_sensor_model.push(16'h00a0);
        wait_got(9);
        chk(got[8], 16'h00a0);
        cmd(C_STEP, A_NUM, '0);
        q(C_STEP_Q, A_NUM, 16'h0000);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_manual();
        t_rate();
        t_video();
        t_read();
        t_step();
        close_out();
    end
    initial begin
        #400000;
        bad_count++;
        close_out();
    end
endmodule
